// ### src/tsi_pkg.sv
// constants, register map and state types for the teleprinter serial interface
// assumes a 10 MHz system clock and a 16-bit byte-addressed register port
package tsi_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int CHAR_PER_S = 10;
	localparam int UNITS_PER_CHAR = 11;
	// unit time rounded down to whole cycles
	localparam int BIT_CYCLES = CLK_HZ / (CHAR_PER_S * UNITS_PER_CHAR);
	localparam int CNT_W = 17;
	localparam int DATA_BITS = 8;
	localparam int FRAME_UNITS = 11;
	localparam logic [15:0] SERIAL_SPACE_BASE = 16'hff00;
	localparam logic [15:0] ADDR_RX_STAT = 16'hfff0;
	localparam logic [15:0] ADDR_RX_BUF = 16'hfff2;
	localparam logic [15:0] ADDR_TX_STAT = 16'hfff4;
	localparam logic [15:0] ADDR_TX_BUF = 16'hfff6;
	localparam int STAT_DONE_BIT = 7;
	localparam int STAT_IE_BIT = 6;
	localparam int STAT_ERR_BIT = 4;
	localparam logic RX_DONE_RST = 1'b0;
	localparam logic TX_DONE_RST = 1'b1;
	localparam logic IE_RST = 1'b0;
	localparam logic LINE_MARK = 1'b1;
	localparam logic LINE_SPACE = 1'b0;
	localparam logic [15:0] VEC_KBD_OFS = 16'h0004;
	localparam logic [15:0] VEC_PRN_OFS = 16'h0000;
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} tsi_rx_state_t;
	typedef enum {TX_IDLE, TX_BUSY} tsi_tx_state_t;
endpackage : tsi_pkg

// ### src/tsi_rx.sv
// serial receiver for one 11-unit character
// assumes line_in already synchronised to clk_in
`timescale 1ns/1ps
module tsi_rx #(
	parameter int BIT_CYCLES_P = tsi_pkg::BIT_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic line_in,
	output logic valid_out,
	output logic [7:0] data_out
);
	localparam logic [tsi_pkg::CNT_W-1:0] FULL = tsi_pkg::CNT_W'(BIT_CYCLES_P - 1);
	localparam logic [tsi_pkg::CNT_W-1:0] HALF = tsi_pkg::CNT_W'(BIT_CYCLES_P / 2 - 1);
	tsi_pkg::tsi_rx_state_t state_reg;
	logic [tsi_pkg::CNT_W-1:0] cnt_reg;
	logic [2:0] bit_reg;
	logic [7:0] shift_reg;

	always_ff @(posedge clk_in) begin
		valid_out <= 1'b0;
		if (rst_in) begin
			state_reg <= tsi_pkg::RX_IDLE;
			cnt_reg <= '0;
			bit_reg <= '0;
			shift_reg <= '0;
			data_out <= '0;
		end else if (state_reg == tsi_pkg::RX_IDLE) begin
			if (line_in == tsi_pkg::LINE_SPACE) begin
				state_reg <= tsi_pkg::RX_START;
				cnt_reg <= HALF;
			end
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end else begin
			cnt_reg <= FULL;
			case (state_reg)
				tsi_pkg::RX_START: begin
					bit_reg <= '0;
					state_reg <= (line_in == tsi_pkg::LINE_SPACE) ? tsi_pkg::RX_DATA
						: tsi_pkg::RX_IDLE;
				end
				tsi_pkg::RX_DATA: begin
					shift_reg <= {line_in, shift_reg[7:1]};
					bit_reg <= bit_reg + 1'b1;
					if (bit_reg == 3'h7) begin
						state_reg <= tsi_pkg::RX_STOP;
					end
				end
				default: begin
					state_reg <= tsi_pkg::RX_IDLE;
					if (line_in == tsi_pkg::LINE_MARK) begin
						valid_out <= 1'b1;
						data_out <= shift_reg;
					end
				end
			endcase
		end
	end

	property p_rx_mid;
		@(posedge clk_in) disable iff (rst_in)
		(state_reg == tsi_pkg::RX_IDLE && !line_in) |=> (cnt_reg == HALF);
	endproperty
	a_rx_mid: assert property (p_rx_mid) else $error("start not timed to midpoint");
endmodule : tsi_rx

// ### src/tsi_tx.sv
// serial transmitter: start unit, eight data units lsb first, two stop units
// assumes start_in is a one-cycle pulse given only while busy_out is low
`timescale 1ns/1ps
module tsi_tx #(
	parameter int BIT_CYCLES_P = tsi_pkg::BIT_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic start_in,
	input wire logic [7:0] data_in,
	output logic busy_out,
	output logic done_out,
	output logic line_out
);
	localparam logic [tsi_pkg::CNT_W-1:0] FULL = tsi_pkg::CNT_W'(BIT_CYCLES_P - 1);
	tsi_pkg::tsi_tx_state_t state_reg;
	logic [tsi_pkg::CNT_W-1:0] cnt_reg;
	logic [3:0] unit_reg;
	logic [10:0] shift_reg;

	assign busy_out = (state_reg == tsi_pkg::TX_BUSY);

	always_ff @(posedge clk_in) begin
		done_out <= 1'b0;
		if (rst_in) begin
			state_reg <= tsi_pkg::TX_IDLE;
			cnt_reg <= '0;
			unit_reg <= '0;
			shift_reg <= '1;
			line_out <= tsi_pkg::LINE_MARK;
		end else if (state_reg == tsi_pkg::TX_IDLE) begin
			if (start_in) begin
				state_reg <= tsi_pkg::TX_BUSY;
				shift_reg <= {2'b11, data_in, tsi_pkg::LINE_SPACE};
				line_out <= tsi_pkg::LINE_SPACE;
				cnt_reg <= FULL;
				unit_reg <= '0;
			end
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end else if (unit_reg == 4'(tsi_pkg::FRAME_UNITS - 1)) begin
			state_reg <= tsi_pkg::TX_IDLE;
			done_out <= 1'b1;
			line_out <= tsi_pkg::LINE_MARK;
		end else begin
			cnt_reg <= FULL;
			unit_reg <= unit_reg + 1'b1;
			line_out <= shift_reg[1];
			shift_reg <= {1'b1, shift_reg[10:1]};
		end
	end

	property p_tx_start;
		@(posedge clk_in) disable iff (rst_in)
		(start_in && !busy_out) |=> (line_out == tsi_pkg::LINE_SPACE) && busy_out;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("frame did not open with space");
endmodule : tsi_tx

// ### src/tsi_top.sv
// teleprinter serial interface: registers, request bit, poll answer, serial link
// assumes bus strobes and poll come from logic on SYS_CLK_IN, the line from a pin
`timescale 1ns/1ps
// Contract
// - decode only within top serial address page
// - accept one access per clock, never stall
// - raise request on the single serial level
// - status and buffers readable, byte or word
// - done flag marks finished peripheral operation
// - enable bit gates rising status requests
// - error flag reports receive fault
// - request bit set by rising status, answers poll
// - status read clears request bit
// - vector base taken from static strap
// - eight-bit characters, eighth bit kept
// - eleven units, ten chars per second, duplex
// - received char loads buffer, sets done
// - buffer read clears done and error
// - char over unread done sets error
// - buffer write clears done, sent sets it
module tsi_top #(
	parameter int BIT_CYCLES_P = tsi_pkg::BIT_CYCLES
) (
	input wire logic SYS_CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic [15:0] ADDR_IN,
	input wire logic [15:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [15:0] RDATA_OUT,
	input wire logic RXD_IN,
	output logic TXD_OUT,
	output logic IRQ_SERIAL_OUT,
	input wire logic POLL_IN,
	output logic POLL_ACK_OUT,
	input wire logic [15:0] VECTOR_BASE_IN,
	output logic [15:0] VECTOR_OUT
);
	logic rxd_meta_reg;
	logic rxd_sync_reg;
	logic in_space;
	logic hit_rx_stat;
	logic hit_rx_buf;
	logic hit_tx_stat;
	logic hit_tx_buf;
	logic rd_rx_stat;
	logic rd_rx_buf;
	logic rd_tx_stat;
	logic wr_rx_stat;
	logic wr_tx_stat;
	logic wr_tx_buf;
	logic rx_valid;
	logic [7:0] rx_data;
	logic rx_done_reg;
	logic rx_err_reg;
	logic rx_ie_reg;
	logic [7:0] rx_buf_reg;
	logic rx_done_d_reg;
	logic rx_err_d_reg;
	logic rx_set;
	logic rx_req_reg;
	logic tx_done_reg;
	logic tx_ie_reg;
	logic [7:0] tx_buf_reg;
	logic tx_pend_reg;
	logic tx_done_d_reg;
	logic tx_set;
	logic tx_req_reg;
	logic tx_start;
	logic tx_busy;
	logic tx_done_ev;
	logic [15:0] vec_base_reg;
	logic [7:0] rx_stat_byte;
	logic [7:0] tx_stat_byte;

	// line synchroniser
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			rxd_meta_reg <= tsi_pkg::LINE_MARK;
			rxd_sync_reg <= tsi_pkg::LINE_MARK;
		end else begin
			rxd_meta_reg <= RXD_IN;
			rxd_sync_reg <= rxd_meta_reg;
		end
	end

	// address decode
	always_comb begin
		in_space = (ADDR_IN >= tsi_pkg::SERIAL_SPACE_BASE);
		hit_rx_stat = 1'b0;
		hit_rx_buf = 1'b0;
		hit_tx_stat = 1'b0;
		hit_tx_buf = 1'b0;
		if (!in_space) begin
			hit_rx_stat = 1'b0;
		end else if (ADDR_IN == tsi_pkg::ADDR_RX_STAT) begin
			hit_rx_stat = 1'b1;
		end else if (ADDR_IN == tsi_pkg::ADDR_RX_BUF) begin
			hit_rx_buf = 1'b1;
		end else if (ADDR_IN == tsi_pkg::ADDR_TX_STAT) begin
			hit_tx_stat = 1'b1;
		end else if (ADDR_IN == tsi_pkg::ADDR_TX_BUF) begin
			hit_tx_buf = 1'b1;
		end
	end

	// single-cycle strobes, no wait states
	assign rd_rx_stat = RD_IN && hit_rx_stat;
	assign rd_rx_buf = RD_IN && hit_rx_buf;
	assign rd_tx_stat = RD_IN && hit_tx_stat;
	assign wr_rx_stat = WR_IN && hit_rx_stat;
	assign wr_tx_stat = WR_IN && hit_tx_stat;
	assign wr_tx_buf = WR_IN && hit_tx_buf;

	// status bytes
	always_comb begin
		rx_stat_byte = 8'h00;
		rx_stat_byte[tsi_pkg::STAT_DONE_BIT] = rx_done_reg;
		rx_stat_byte[tsi_pkg::STAT_IE_BIT] = rx_ie_reg;
		rx_stat_byte[tsi_pkg::STAT_ERR_BIT] = rx_err_reg;
		tx_stat_byte = 8'h00;
		tx_stat_byte[tsi_pkg::STAT_DONE_BIT] = tx_done_reg;
		tx_stat_byte[tsi_pkg::STAT_IE_BIT] = tx_ie_reg;
	end

	// read data, valid only in the cycle after the read
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			RDATA_OUT <= 16'h0000;
		end else if (!RD_IN) begin
			RDATA_OUT <= 16'h0000;
		end else if (hit_rx_stat) begin
			RDATA_OUT <= {8'h00, rx_stat_byte};
		end else if (hit_rx_buf) begin
			RDATA_OUT <= {8'h00, rx_buf_reg};
		end else if (hit_tx_stat) begin
			RDATA_OUT <= {8'h00, tx_stat_byte};
		end else if (hit_tx_buf) begin
			RDATA_OUT <= {8'h00, tx_buf_reg};
		end else begin
			RDATA_OUT <= 16'h0000;
		end
	end

	// interrupt enables
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			rx_ie_reg <= tsi_pkg::IE_RST;
			tx_ie_reg <= tsi_pkg::IE_RST;
		end else begin
			if (wr_rx_stat) begin
				rx_ie_reg <= WDATA_IN[tsi_pkg::STAT_IE_BIT];
			end
			if (wr_tx_stat) begin
				tx_ie_reg <= WDATA_IN[tsi_pkg::STAT_IE_BIT];
			end
		end
	end

	// receiver
	tsi_rx #(
		.BIT_CYCLES_P(BIT_CYCLES_P)
	) u_rx (
		.clk_in(SYS_CLK_IN),
		.rst_in(SYS_RST_IN),
		.line_in(rxd_sync_reg),
		.valid_out(rx_valid),
		.data_out(rx_data)
	);

	// receive buffer and flags
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			rx_buf_reg <= 8'h00;
			rx_done_reg <= tsi_pkg::RX_DONE_RST;
			rx_err_reg <= 1'b0;
		end else begin
			if (rx_valid) begin
				rx_buf_reg <= rx_data;
				rx_done_reg <= 1'b1;
			end else if (rd_rx_buf) begin
				rx_done_reg <= 1'b0;
			end
			if (rx_valid && rx_done_reg && !rd_rx_buf) begin
				rx_err_reg <= 1'b1;
			end else if (rd_rx_buf) begin
				rx_err_reg <= 1'b0;
			end
		end
	end

	// transmit buffer, pending and done
	assign tx_start = tx_pend_reg && !tx_busy;

	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			tx_buf_reg <= 8'h00;
			tx_pend_reg <= 1'b0;
			tx_done_reg <= tsi_pkg::TX_DONE_RST;
		end else begin
			if (wr_tx_buf) begin
				tx_buf_reg <= WDATA_IN[7:0];
				tx_pend_reg <= 1'b1;
				tx_done_reg <= 1'b0;
			end else begin
				if (tx_start) begin
					tx_pend_reg <= 1'b0;
				end
				if (tx_done_ev && !tx_pend_reg) begin
					tx_done_reg <= 1'b1;
				end
			end
		end
	end

	// transmitter
	tsi_tx #(
		.BIT_CYCLES_P(BIT_CYCLES_P)
	) u_tx (
		.clk_in(SYS_CLK_IN),
		.rst_in(SYS_RST_IN),
		.start_in(tx_start),
		.data_in(tx_buf_reg),
		.busy_out(tx_busy),
		.done_out(tx_done_ev),
		.line_out(TXD_OUT)
	);

	// edge detect of status flags
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			rx_done_d_reg <= tsi_pkg::RX_DONE_RST;
			rx_err_d_reg <= 1'b0;
			tx_done_d_reg <= tsi_pkg::TX_DONE_RST;
		end else begin
			rx_done_d_reg <= rx_done_reg;
			rx_err_d_reg <= rx_err_reg;
			tx_done_d_reg <= tx_done_reg;
		end
	end

	assign rx_set = rx_ie_reg && ((rx_done_reg && !rx_done_d_reg)
		|| (rx_err_reg && !rx_err_d_reg));
	assign tx_set = tx_ie_reg && tx_done_reg && !tx_done_d_reg;

	// request bits, set wins over status-read clear
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			rx_req_reg <= 1'b0;
			tx_req_reg <= 1'b0;
		end else begin
			if (rx_set) begin
				rx_req_reg <= 1'b1;
			end else if (rd_rx_stat) begin
				rx_req_reg <= 1'b0;
			end
			if (tx_set) begin
				tx_req_reg <= 1'b1;
			end else if (rd_tx_stat) begin
				tx_req_reg <= 1'b0;
			end
		end
	end

	// strap capture, request line and poll answer
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			vec_base_reg <= VECTOR_BASE_IN;
			IRQ_SERIAL_OUT <= 1'b0;
			POLL_ACK_OUT <= 1'b0;
			VECTOR_OUT <= 16'h0000;
		end else begin
			IRQ_SERIAL_OUT <= rx_req_reg || tx_req_reg;
			POLL_ACK_OUT <= POLL_IN && (rx_req_reg || tx_req_reg);
			if (!POLL_IN) begin
				VECTOR_OUT <= 16'h0000;
			end else if (rx_req_reg) begin
				VECTOR_OUT <= vec_base_reg + tsi_pkg::VEC_KBD_OFS;
			end else if (tx_req_reg) begin
				VECTOR_OUT <= vec_base_reg + tsi_pkg::VEC_PRN_OFS;
			end else begin
				VECTOR_OUT <= 16'h0000;
			end
		end
	end

	default clocking cb @(posedge SYS_CLK_IN);
	endclocking
	default disable iff (SYS_RST_IN);

	sequence s_char_in;
		rx_valid;
	endsequence

	sequence s_overrun;
		rx_valid && rx_done_reg && !rd_rx_buf;
	endsequence

	property p_unmapped;
		(RD_IN && ADDR_IN < tsi_pkg::SERIAL_SPACE_BASE) |=> (RDATA_OUT == 16'h0000);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("read outside serial space");

	property p_rx_load;
		s_char_in |=> rx_done_reg && (rx_buf_reg == $past(rx_data));
	endproperty
	a_rx_load: assert property (p_rx_load) else $error("char not loaded");

	property p_rx_clear;
		(rd_rx_buf && !rx_valid) |=> !rx_done_reg && !rx_err_reg;
	endproperty
	a_rx_clear: assert property (p_rx_clear) else $error("buffer read kept flags");

	property p_overrun;
		s_overrun |=> rx_err_reg ##1 (rx_stat_byte[tsi_pkg::STAT_ERR_BIT] || $past(rd_rx_buf));
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");

	property p_tx_clear;
		wr_tx_buf |=> !tx_done_reg ##1 (tx_busy || !tx_done_reg);
	endproperty
	a_tx_clear: assert property (p_tx_clear) else $error("write did not start output");

	property p_req_set;
		($rose(rx_done_reg) && rx_ie_reg) |=> rx_req_reg ##1 IRQ_SERIAL_OUT;
	endproperty
	a_req_set: assert property (p_req_set) else $error("request not raised");

	property p_req_clear;
		(rd_tx_stat && !tx_set) |=> !tx_req_reg;
	endproperty
	a_req_clear: assert property (p_req_clear) else $error("status read kept request");

	property p_no_req;
		(!rx_req_reg && !tx_req_reg) |=> !IRQ_SERIAL_OUT && !POLL_ACK_OUT;
	endproperty
	a_no_req: assert property (p_no_req) else $error("spurious request");

	property p_poll;
		(POLL_IN && rx_req_reg) |=> POLL_ACK_OUT
			&& (VECTOR_OUT == vec_base_reg + tsi_pkg::VEC_KBD_OFS);
	endproperty
	a_poll: assert property (p_poll) else $error("poll answer wrong");

	property p_mask;
		(!rx_ie_reg && !rx_req_reg && !rd_rx_stat) |=> !rx_req_reg;
	endproperty
	a_mask: assert property (p_mask) else $error("request while disabled");
endmodule : tsi_top

// ### tb/tsi_term.sv
// terminal model: keyboard sender and printer receiver on the serial loop
// assumes the interface clock, unit time given in clock cycles
`timescale 1ns/1ps
module tsi_term #(
	parameter int BIT_P = 16
) (
	input wire logic clk_in,
	input wire logic line_in,
	output logic line_out
);
	logic [7:0] got [0:7];
	logic [7:0] c;
	int n_got;
	initial begin
		line_out = 1'b1;
		n_got = 0;
	end
	// keyboard frame, codes chosen by the caller outside e0..fc and fe
	task automatic send(input logic [7:0] ch);
		logic [10:0] f;
		f = {2'b11, ch, 1'b0};
		@(posedge clk_in);
		for (int i = 0; i < 11; i++) begin
			line_out <= f[i];
			repeat (BIT_P) @(posedge clk_in);
		end
	endtask : send
	// printer side, sampled mid unit on the falling clock edge
	always begin
		@(negedge line_in);
		repeat (BIT_P / 2) @(negedge clk_in);
		if (line_in === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_P) @(negedge clk_in);
				c[i] = line_in;
			end
			repeat (BIT_P) @(negedge clk_in);
			if (line_in === 1'b1 && n_got < 8) begin
				got[n_got] = c;
				n_got++;
			end
		end
	end
endmodule : tsi_term

// ### tb/teleprinter_serial_interface_tb_top.sv
// self-checking bench: register port, serial loop to terminal model, poll
// assumes a 100 ns clock and a 16-cycle unit time
`timescale 1ns/1ps
module teleprinter_serial_interface_tb_top;
	localparam int BITC = 16;
	localparam logic [15:0] VBASE = 16'h00f4;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic poll = 1'b0;
	logic [15:0] rdata;
	logic [15:0] vector;
	logic [15:0] junk;
	logic rxd;
	logic txd;
	logic irq;
	logic poll_ack;
	int miscompares = 0;
	int n_compared = 0;
	int cyc = 0;
	always #50 sys_clk = ~sys_clk;
	tsi_top #(.BIT_CYCLES_P(BITC)) u_tsi_top (.SYS_CLK_IN(sys_clk), .SYS_RST_IN(sys_rst),
		.ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
		.RXD_IN(rxd), .TXD_OUT(txd), .IRQ_SERIAL_OUT(irq), .POLL_IN(poll),
		.POLL_ACK_OUT(poll_ack), .VECTOR_BASE_IN(VBASE), .VECTOR_OUT(vector));
	tsi_term #(.BIT_P(BITC)) u_tsi_term (.clk_in(sys_clk), .line_in(txd), .line_out(rxd));
	task automatic stop_test();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			stop_test();
		end
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask : bus_wr
	task automatic bus_rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : bus_rd
	task automatic chk_rd(input string what, input logic [15:0] a, input logic [15:0] exp);
		logic [15:0] d;
		bus_rd(a, d);
		check(what, d, exp);
	endtask : chk_rd
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : wait_cyc
	task automatic wait_got(input int n);
		for (int i = 0; i < 3000 && u_tsi_term.n_got < n; i++) @(posedge sys_clk);
		check("printed count", 16'(u_tsi_term.n_got), 16'(n));
	endtask : wait_got
	// poll the serial level, answer expected one cycle later
	task automatic poll_chk(input logic aexp, input logic [15:0] vexp);
		@(posedge sys_clk);
		poll <= 1'b1;
		@(posedge sys_clk);
		#1 check("poll ack", {15'h0000, poll_ack}, {15'h0000, aexp});
		check("vector", vector, vexp);
		@(posedge sys_clk);
		poll <= 1'b0;
	endtask : poll_chk
	task automatic t_reset();
		chk_rd("rx status reset", tsi_pkg::ADDR_RX_STAT, 16'h0000);
		chk_rd("tx status reset", tsi_pkg::ADDR_TX_STAT, 16'h0080);
		chk_rd("unmapped read", 16'hfef0, 16'h0000);
		bus_wr(16'hfef0, 16'h0040);
		chk_rd("alias write", tsi_pkg::ADDR_RX_STAT, 16'h0000);
		bus_wr(tsi_pkg::ADDR_RX_STAT, 16'h0040);
		chk_rd("enable rw", tsi_pkg::ADDR_RX_STAT, 16'h0040);
		bus_wr(tsi_pkg::ADDR_RX_STAT, 16'h0000);
		check("irq idle", {15'h0000, irq}, 16'h0000);
	endtask : t_reset
	task automatic t_rx_char();
		u_tsi_term.send(8'hb1);
		wait_cyc(24);
		check("irq masked", {15'h0000, irq}, 16'h0000);
		chk_rd("rx done", tsi_pkg::ADDR_RX_STAT, 16'h0080);
		chk_rd("rx buffer", tsi_pkg::ADDR_RX_BUF, 16'h00b1);
		chk_rd("rx cleared", tsi_pkg::ADDR_RX_STAT, 16'h0000);
	endtask : t_rx_char
	task automatic t_overrun();
		u_tsi_term.send(8'h41);
		u_tsi_term.send(8'h7e);
		wait_cyc(24);
		chk_rd("overrun", tsi_pkg::ADDR_RX_STAT, 16'h0090);
		chk_rd("overrun buffer", tsi_pkg::ADDR_RX_BUF, 16'h007e);
		chk_rd("error cleared", tsi_pkg::ADDR_RX_STAT, 16'h0000);
	endtask : t_overrun
	task automatic t_duplex();
		fork
			u_tsi_term.send(8'h5a);
			begin
				bus_wr(tsi_pkg::ADDR_TX_BUF, 16'h00c3);
				chk_rd("tx busy", tsi_pkg::ADDR_TX_STAT, 16'h0000);
			end
		join
		wait_got(1);
		check("printed 0", {8'h00, u_tsi_term.got[0]}, 16'h00c3);
		wait_cyc(24);
		chk_rd("tx done", tsi_pkg::ADDR_TX_STAT, 16'h0080);
		chk_rd("duplex rx", tsi_pkg::ADDR_RX_BUF, 16'h005a);
	endtask : t_duplex
	task automatic t_back_to_back();
		bus_wr(tsi_pkg::ADDR_TX_BUF, 16'h0011);
		bus_wr(tsi_pkg::ADDR_TX_BUF, 16'h00ff);
		wait_got(3);
		check("printed 1", {8'h00, u_tsi_term.got[1]}, 16'h0011);
		check("printed 2", {8'h00, u_tsi_term.got[2]}, 16'h00ff);
	endtask : t_back_to_back
	task automatic t_irq_rx();
		bus_wr(tsi_pkg::ADDR_RX_STAT, 16'h0040);
		u_tsi_term.send(8'h8d);
		wait_cyc(24);
		check("rx irq", {15'h0000, irq}, 16'h0001);
		poll_chk(1'b1, VBASE + 16'h0004);
		chk_rd("rx status ie", tsi_pkg::ADDR_RX_STAT, 16'h00c0);
		wait_cyc(3);
		check("rx irq cleared", {15'h0000, irq}, 16'h0000);
		bus_rd(tsi_pkg::ADDR_RX_BUF, junk);
		bus_wr(tsi_pkg::ADDR_RX_STAT, 16'h0000);
	endtask : t_irq_rx
	task automatic t_irq_tx();
		bus_wr(tsi_pkg::ADDR_TX_STAT, 16'h0040);
		wait_cyc(4);
		check("no irq on enable", {15'h0000, irq}, 16'h0000);
		bus_wr(tsi_pkg::ADDR_TX_BUF, 16'h002a);
		wait_got(4);
		check("printed 3", {8'h00, u_tsi_term.got[3]}, 16'h002a);
		wait_cyc(40);
		check("tx irq", {15'h0000, irq}, 16'h0001);
		poll_chk(1'b1, VBASE);
		chk_rd("tx status ie", tsi_pkg::ADDR_TX_STAT, 16'h00c0);
		wait_cyc(3);
		check("tx irq cleared", {15'h0000, irq}, 16'h0000);
		poll_chk(1'b0, 16'h0000);
		bus_wr(tsi_pkg::ADDR_TX_STAT, 16'h0000);
	endtask : t_irq_tx
	initial begin
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_rx_char();
		t_overrun();
		t_duplex();
		t_back_to_back();
		t_irq_rx();
		t_irq_tx();
		stop_test();
	end
endmodule : teleprinter_serial_interface_tb_top
